// *** logic/slds_pkg.sv ***
// Constants shared by the six-lane deserializer with spare input multiplexing.
// Assumes a 50 MHz system clock and an APB register bus with 32-bit data.
package slds_pkg;
  localparam int SLDS_LANES = 6;
  localparam int SLDS_WORD_BITS = 10;
  localparam int SLDS_FRAME_BITS = 12;
  // Serial bit period as seen by the oversampling clock.
  localparam logic [3:0] SLDS_BIT_CYC = 4'h4;
  localparam logic [3:0] SLDS_HALF_BIT_CYC = 4'h2;
  // A missed embedded clock edge is declared after this many idle cycles.
  localparam logic [3:0] SLDS_EDGE_WAIT_CYC = 4'hC;
  localparam logic [3:0] SLDS_START_IDX = 4'h0;
  localparam logic [3:0] SLDS_MID_IDX = 4'h6;
  localparam logic [3:0] SLDS_STOP_IDX = 4'hB;
  localparam logic [6:0] SLDS_LOCK_WORDS = 7'h50;
  localparam logic [1:0] SLDS_MISS_LIMIT = 2'h2;
  // The reference clock counts as stopped after this many cycles with no edge.
  localparam logic [4:0] SLDS_REF_LOSS_CYC = 5'h10;
  localparam logic [2:0] SLDS_CODE_MON_OFF = 3'h6;
  localparam logic [2:0] SLDS_CODE_SPARE_MON = 3'h7;
  localparam logic [2:0] SLDS_CODE_RESET = 3'h7;
  // Register byte offsets.
  localparam logic [11:0] SLDS_STATUS_OFS = 12'h000;
  localparam logic [11:0] SLDS_MASK_OFS = 12'h004;
  localparam logic [11:0] SLDS_STATE_OFS = 12'h008;
  // Status and mask layout: lock gained in [5:0], lock lost in [13:8].
  localparam int SLDS_GAIN_POS = 0;
  localparam int SLDS_LOSS_POS = 8;
  // State register layout.
  localparam int SLDS_ST_LOCK_POS = 0;
  localparam int SLDS_ST_CODE_POS = 8;
  localparam int SLDS_ST_PWR_POS = 12;
  localparam int SLDS_ST_OE_POS = 13;
  localparam int SLDS_ST_REF_POS = 14;
  localparam logic [31:0] SLDS_MASK_RESET = 32'h00000000;
  localparam logic [31:0] SLDS_EVENT_BITS = 32'h00003F3F;
  // Synchroniser vector layout.
  localparam int SLDS_SY_SPARE = 6;
  localparam int SLDS_SY_PWR = 7;
  localparam int SLDS_SY_OE = 8;
  localparam int SLDS_SY_RISE = 9;
  localparam int SLDS_SY_REF = 10;
  localparam int SLDS_SY_CODE = 11;
  localparam int SLDS_SY_W = 14;
  typedef enum logic [0:0] {SLDS_HUNT, SLDS_FRAME} slds_state_t;
endpackage : slds_pkg

// *** logic/slds_deser.sv ***
// Six embedded-clock 1:10 deserializer lanes, a spare serial input that can
// replace any lane, a raw monitor output and an APB status/interrupt block.
// Assumes serial inputs are oversampled by sys_clk_i at SLDS_BIT_CYC per bit.
module slds_deser
  import slds_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  input wire logic [5:0] lane_serial_i,
  input wire logic spare_serial_in_i,
  input wire logic local_reference_clock_i,
  input wire logic power_down_n_i,
  input wire logic output_enable_i,
  input wire logic strobe_rising_i,
  input wire logic [2:0] spare_code_i,
  output logic [59:0] lane_data_o,
  output logic [5:0] lane_data_oe_o,
  output logic [5:0] recovered_clk_o,
  output logic [5:0] recovered_clk_oe_o,
  output logic [5:0] lock_n_o,
  output logic [5:0] lock_n_oe_o,
  output logic raw_monitor_out_o,
  output logic raw_monitor_out_oe_o
);

  logic [SLDS_SY_W-1:0] sync1_reg;
  logic [SLDS_SY_W-1:0] sync2_reg;
  logic [5:0] lane_prev_reg;
  logic ref_prev_reg;
  logic [4:0] ref_gap_reg;
  logic ref_alive;
  logic pwr_ok;
  logic out_en;
  logic rise_sel;
  logic [2:0] code;
  logic [2:0] code_prev_reg;
  logic [5:0] restart;
  logic [5:0] lane_in;
  logic [5:0] lane_rise;
  slds_state_t st_reg [SLDS_LANES];
  logic [3:0] ph_reg [SLDS_LANES];
  logic [3:0] bit_reg [SLDS_LANES];
  logic [3:0] wait_reg [SLDS_LANES];
  logic [6:0] good_reg [SLDS_LANES];
  logic [1:0] miss_reg [SLDS_LANES];
  logic [9:0] shift_reg [SLDS_LANES];
  logic [5:0] start_ok_reg;
  logic [5:0] locked_reg;
  logic [5:0] locked_prev_reg;
  logic [5:0] rclk_reg;
  logic [59:0] data_reg;
  logic [31:0] status_reg;
  logic [31:0] mask_reg;
  logic [31:0] events;
  logic apb_access;
  logic addr_ok;
  logic [31:0] state_word;

  // True when the spare code routes the spare input onto the given lane.
  function automatic logic lane_hit(input logic [2:0] c, input int lane);
    lane_hit = (c == lane[2:0]);
  endfunction : lane_hit

  // Every pin apart from the APB bus and reset arrives from outside this clock's domain.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {spare_code_i, local_reference_clock_i, strobe_rising_i,
                    output_enable_i, power_down_n_i, spare_serial_in_i, lane_serial_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign pwr_ok = sync2_reg[SLDS_SY_PWR];
  assign out_en = sync2_reg[SLDS_SY_OE];
  assign rise_sel = sync2_reg[SLDS_SY_RISE];
  assign code = sync2_reg[SLDS_SY_CODE +: 3];

  // Lanes only train while the reference clock is seen toggling.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_prev_reg <= 1'b0;
      ref_gap_reg <= SLDS_REF_LOSS_CYC;
    end else begin
      ref_prev_reg <= sync2_reg[SLDS_SY_REF];
      if (ref_prev_reg != sync2_reg[SLDS_SY_REF]) begin
        ref_gap_reg <= '0;
      end else if (ref_gap_reg != SLDS_REF_LOSS_CYC) begin
        ref_gap_reg <= ref_gap_reg + 5'h01;
      end
    end
  end

  assign ref_alive = (ref_gap_reg != SLDS_REF_LOSS_CYC);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_prev_reg <= SLDS_CODE_RESET;
    end else begin
      code_prev_reg <= code;
    end
  end

  always_comb begin
    for (int i = 0; i < SLDS_LANES; i++) begin
      // Code 7 and 6 leave every lane on its own input.
      lane_in[i] = lane_hit(code, i) ? sync2_reg[SLDS_SY_SPARE] : sync2_reg[i];
      restart[i] = (code != code_prev_reg) &&
                   (lane_hit(code, i) || lane_hit(code_prev_reg, i));
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lane_prev_reg <= '0;
    end else begin
      lane_prev_reg <= lane_in;
    end
  end

  // The stop-to-start transition is the embedded clock edge.
  assign lane_rise = lane_in & ~lane_prev_reg;

  // Each lane runs its own recovery from its own counters only.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < SLDS_LANES; i++) begin
        st_reg[i] <= SLDS_HUNT;
        ph_reg[i] <= '0;
        bit_reg[i] <= '0;
        wait_reg[i] <= '0;
        good_reg[i] <= '0;
        miss_reg[i] <= '0;
        shift_reg[i] <= '0;
      end
      start_ok_reg <= '0;
      locked_reg <= '0;
      rclk_reg <= '0;
      data_reg <= '0;
    end else begin
      for (int i = 0; i < SLDS_LANES; i++) begin
        if (!pwr_ok || restart[i]) begin
          st_reg[i] <= SLDS_HUNT;
          wait_reg[i] <= '0;
          good_reg[i] <= '0;
          miss_reg[i] <= '0;
          locked_reg[i] <= 1'b0;
          rclk_reg[i] <= 1'b0;
        end else begin
          case (st_reg[i])
            SLDS_HUNT: begin
              if (lane_rise[i]) begin
                st_reg[i] <= SLDS_FRAME;
                ph_reg[i] <= SLDS_HALF_BIT_CYC;
                bit_reg[i] <= SLDS_START_IDX;
                wait_reg[i] <= '0;
              end else if (wait_reg[i] == SLDS_EDGE_WAIT_CYC) begin
                wait_reg[i] <= '0;
                good_reg[i] <= '0;
                if (locked_reg[i]) begin
                  if (miss_reg[i] == SLDS_MISS_LIMIT - 2'h1) begin
                    locked_reg[i] <= 1'b0;
                    rclk_reg[i] <= 1'b0;
                    miss_reg[i] <= '0;
                  end else begin
                    miss_reg[i] <= miss_reg[i] + 2'h1;
                  end
                end
              end else begin
                wait_reg[i] <= wait_reg[i] + 4'h1;
              end
            end
            SLDS_FRAME: begin
              if (ph_reg[i] != 4'h0) begin
                ph_reg[i] <= ph_reg[i] - 4'h1;
              end else begin
                ph_reg[i] <= SLDS_BIT_CYC - 4'h1;
                bit_reg[i] <= bit_reg[i] + 4'h1;
                if (bit_reg[i] == SLDS_START_IDX) begin
                  start_ok_reg[i] <= lane_in[i];
                end else if (bit_reg[i] != SLDS_STOP_IDX) begin
                  shift_reg[i][bit_reg[i] - 4'h1] <= lane_in[i];
                end
                if (bit_reg[i] == SLDS_MID_IDX && locked_reg[i]) begin
                  rclk_reg[i] <= rise_sel;
                end
                if (bit_reg[i] == SLDS_STOP_IDX) begin
                  st_reg[i] <= SLDS_HUNT;
                  wait_reg[i] <= '0;
                  if (start_ok_reg[i] && !lane_in[i] && ref_alive) begin
                    miss_reg[i] <= '0;
                    if (locked_reg[i]) begin
                      data_reg[i*10 +: 10] <= shift_reg[i];
                      rclk_reg[i] <= ~rise_sel;
                    end else if (good_reg[i] == SLDS_LOCK_WORDS - 7'h01) begin
                      // Lock and the first valid word appear together.
                      locked_reg[i] <= 1'b1;
                      data_reg[i*10 +: 10] <= shift_reg[i];
                      rclk_reg[i] <= ~rise_sel;
                    end else begin
                      good_reg[i] <= good_reg[i] + 7'h01;
                    end
                  end else begin
                    good_reg[i] <= '0;
                    if (locked_reg[i]) begin
                      if (miss_reg[i] == SLDS_MISS_LIMIT - 2'h1) begin
                        locked_reg[i] <= 1'b0;
                        rclk_reg[i] <= 1'b0;
                        miss_reg[i] <= '0;
                      end else begin
                        miss_reg[i] <= miss_reg[i] + 2'h1;
                      end
                    end
                  end
                end
              end
            end
            default: begin
              st_reg[i] <= SLDS_HUNT;
            end
          endcase
        end
      end
    end
  end

  // Pin drivers; the output enables model the high-impedance states.
  always_comb begin
    lane_data_o = data_reg;
    recovered_clk_o = rclk_reg;
    lock_n_o = ~locked_reg;
    lock_n_oe_o = {SLDS_LANES{pwr_ok}};
    for (int i = 0; i < SLDS_LANES; i++) begin
      lane_data_oe_o[i] = pwr_ok && out_en && locked_reg[i];
      recovered_clk_oe_o[i] = pwr_ok && out_en && locked_reg[i];
    end
    // The monitor passes the synchronised raw stream with no frame decoding.
    if (code == SLDS_CODE_SPARE_MON) begin
      raw_monitor_out_o = sync2_reg[SLDS_SY_SPARE];
    end else if (code == SLDS_CODE_MON_OFF) begin
      raw_monitor_out_o = 1'b0;
    end else begin
      raw_monitor_out_o = sync2_reg[code];
    end
    raw_monitor_out_oe_o = pwr_ok && out_en && (code != SLDS_CODE_MON_OFF);
  end

  // Lock transitions become sticky interrupt events.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      locked_prev_reg <= '0;
    end else begin
      locked_prev_reg <= locked_reg;
    end
  end

  always_comb begin
    events = '0;
    events[SLDS_GAIN_POS +: 6] = locked_reg & ~locked_prev_reg;
    events[SLDS_LOSS_POS +: 6] = ~locked_reg & locked_prev_reg;
  end

  assign apb_access = psel_i && penable_i;
  assign addr_ok = (paddr_i == SLDS_STATUS_OFS) || (paddr_i == SLDS_MASK_OFS) ||
                   (paddr_i == SLDS_STATE_OFS);

  // A new event in the clearing cycle survives the write-one-to-clear.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg <= '0;
    end else if (apb_access && pwrite_i && paddr_i == SLDS_STATUS_OFS) begin
      status_reg <= ((status_reg & ~pwdata_i) | events) & SLDS_EVENT_BITS;
    end else begin
      status_reg <= (status_reg | events) & SLDS_EVENT_BITS;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_reg <= SLDS_MASK_RESET;
    end else if (apb_access && pwrite_i && paddr_i == SLDS_MASK_OFS) begin
      mask_reg <= pwdata_i & SLDS_EVENT_BITS;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_reg & mask_reg);
    end
  end

  always_comb begin
    state_word = '0;
    state_word[SLDS_ST_LOCK_POS +: 6] = locked_reg;
    state_word[SLDS_ST_CODE_POS +: 3] = code;
    state_word[SLDS_ST_PWR_POS] = pwr_ok;
    state_word[SLDS_ST_OE_POS] = out_en;
    state_word[SLDS_ST_REF_POS] = ref_alive;
  end

  // Zero-wait slave; unmapped addresses answer with an error and read zero.
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok;

  always_comb begin
    case (paddr_i)
      SLDS_STATUS_OFS: prdata_o = status_reg;
      SLDS_MASK_OFS: prdata_o = mask_reg;
      SLDS_STATE_OFS: prdata_o = state_word;
      default: prdata_o = '0;
    endcase
  end

endmodule : slds_deser

// *** testbench/slds_deser_monitor.sv ***
// Pin-level checker for the six-lane deserializer, bound to slds_deser.
// Assumes two-stage input synchronisers, so inputs are given four cycles to settle.
module slds_deser_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic spare_serial_in_i,
  input wire logic power_down_n_i,
  input wire logic output_enable_i,
  input wire logic [2:0] spare_code_i,
  input wire logic [5:0] lane_data_oe_o,
  input wire logic [5:0] recovered_clk_o,
  input wire logic [5:0] recovered_clk_oe_o,
  input wire logic [5:0] lock_n_o,
  input wire logic [5:0] lock_n_oe_o,
  input wire logic raw_monitor_out_o,
  input wire logic raw_monitor_out_oe_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_data_needs_lock: assert property ((lane_data_oe_o & lock_n_o) == 6'h00)
    else $error("lane data driven while unlocked");
  a_clk_oe_pairs: assert property (recovered_clk_oe_o == lane_data_oe_o)
    else $error("clock enable differs from data enable");
  a_rclk_idle: assert property ((lock_n_o == 6'h3F) [*2] |-> $stable(recovered_clk_o))
    else $error("recovered clock moved while unlocked");
  a_pd_all_off: assert property (!power_down_n_i [*4] |-> lane_data_oe_o == 6'h00
    && !raw_monitor_out_oe_o && lock_n_oe_o == 6'h00)
    else $error("output driven in power-down");
  a_oe_low_off: assert property (!output_enable_i [*4] |-> recovered_clk_oe_o == 6'h00
    && !raw_monitor_out_oe_o)
    else $error("output driven while disabled");
  a_lock_pins_on: assert property (power_down_n_i [*4] |-> lock_n_oe_o == 6'h3F)
    else $error("lock pins not driven while powered");
  a_mon_code_off: assert property ((spare_code_i == 3'h6) [*4] |-> !raw_monitor_out_oe_o)
    else $error("monitor driven under code six");
  a_mon_spare_img: assert property ((raw_monitor_out_oe_o && spare_code_i == 3'h7) [*4]
    |-> raw_monitor_out_o == $past(spare_serial_in_i, 2))
    else $error("monitor differs from spare input");
  c_lock0: cover property ($fell(lock_n_o[0]));
  c_irq: cover property (irq_o);
  c_mon_spare: cover property (raw_monitor_out_oe_o && spare_code_i == 3'h7);
endmodule : slds_deser_monitor

bind slds_deser slds_deser_monitor slds_deser_monitor_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .spare_serial_in_i(spare_serial_in_i), .power_down_n_i(power_down_n_i),
  .output_enable_i(output_enable_i), .spare_code_i(spare_code_i),
  .lane_data_oe_o(lane_data_oe_o), .recovered_clk_o(recovered_clk_o),
  .recovered_clk_oe_o(recovered_clk_oe_o), .lock_n_o(lock_n_o), .lock_n_oe_o(lock_n_oe_o),
  .raw_monitor_out_o(raw_monitor_out_o), .raw_monitor_out_oe_o(raw_monitor_out_oe_o),
  .irq_o(irq_o));

// *** testbench/slds_ser_model.sv ***
// Serializer model: sends framed words on one serial line at four clocks a bit.
// Assumes its clock is the deserializer's oversampling clock; train_i follows the lock pin.
module slds_ser_model (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic train_i,
  input wire logic [9:0] word_i,
  output logic ser_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One rising edge per frame, so a hunting lane cannot settle on a data bit.
  localparam logic [9:0] TRAIN_WORD = 10'h01F;
  logic [5:0] pos_reg = 6'h00;
  logic [11:0] frame;
  initial ser_o = 1'b0;
  assign frame = {1'b0, train_i ? TRAIN_WORD : word_i, 1'b1};
  // Back-to-back frames run the word rate at the limit the lanes can follow, one frame per 48 clocks.
  always @(posedge clk_i) begin
    if (!en_i) begin
      // A released line toggles so that no stale level can pass for data.
      pos_reg <= 6'h00;
      ser_o <= ~ser_o;
    end else begin
      ser_o <= frame[pos_reg[5:2]];
      pos_reg <= (pos_reg == 6'h2F) ? 6'h00 : pos_reg + 6'h01;
    end
  end
endmodule : slds_ser_model

// *** testbench/slds_deser_tb.sv ***
// Testbench of slds_deser: seven serializer models, APB traffic and pin checks.
// Assumes a zero-wait APB slave and serial lines sampled at four clocks a bit.
module slds_deser_tb
  import slds_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic local_reference_clock = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, mon, mon_oe;
  logic [6:0] ser, h0, h1;
  logic [6:0] en = 7'h00;
  logic [6:0] tr;
  logic rise = 1'b1;
  logic [9:0] w [7];
  logic pd_n = 1'b1;
  logic oe = 1'b1;
  logic [2:0] code = 3'h6;
  logic [59:0] data;
  logic [5:0] doe, rclk, lock_n, lock_oe;
  logic [32:0] exp_q [$];
  logic [31:0] seed = 32'h8D76509A;
  int bad_count = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  always #80 local_reference_clock = ~local_reference_clock;
  always @(posedge clk) begin
    h0 <= ser;
    h1 <= h0;
  end
  for (genvar i = 0; i < 7; i++) begin : g_ser
    slds_ser_model slds_ser_model_i (.clk_i(clk), .en_i(en[i]), .train_i(tr[i]), .word_i(w[i]),
      .ser_o(ser[i]));
  end
  // Each serializer sends training words while the lane it feeds is unlocked.
  assign tr = {(code < 3'h6) ? lock_n[code] : 1'b1, lock_n};
  slds_deser slds_deser_i (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .lane_serial_i(ser[5:0]),
    .spare_serial_in_i(ser[6]), .local_reference_clock_i(local_reference_clock), .power_down_n_i(pd_n),
    .output_enable_i(oe), .strobe_rising_i(rise), .spare_code_i(code), .lane_data_o(data),
    .lane_data_oe_o(doe), .recovered_clk_o(rclk), .recovered_clk_oe_o(), .lock_n_o(lock_n),
    .lock_n_oe_o(lock_oe), .raw_monitor_out_o(mon), .raw_monitor_out_oe_o(mon_oe));
  function automatic void step_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction : step_rand
  function automatic logic [59:0] exp_data();
    logic [59:0] r;
    for (int i = 0; i < 6; i++) r[i*10 +: 10] = (code == i) ? w[6] : w[i];
    return r;
  endfunction : exp_data
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // For reads the data argument is the expected value; the monitor below checks it.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err = 1'b0);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exp_q.push_back({err, d});
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      chk("prdata", exp_q[0][31:0], prdata);
      chk("pslverr", exp_q[0][32], pslverr);
      void'(exp_q.pop_front());
    end
  end
  // The lock output drops a little after a stream change, so give it time first.
  task automatic wait_lock();
    int k;
    k = 0;
    repeat (6) @(posedge clk);
    while (lock_n !== 6'h00 && k < 6000) begin
      @(posedge clk);
      k++;
    end
    chk("lock_n", 6'h00, lock_n);
    // Live words replace training only from the frame after lock.
    repeat (100) @(posedge clk);
  endtask : wait_lock
  initial begin
    int k;
    int j;
    logic b;
    logic s;
    for (int i = 0; i < 7; i++) begin
      step_rand();
      w[i] = seed[9:0];
    end
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, SLDS_MASK_OFS, SLDS_MASK_RESET);
    apb(1'b0, 12'h0FC, 32'h00000000, 1'b1);
    en <= 7'h7F;
    wait_lock();
    #1;
    chk("data", exp_data(), data);
    chk("data oe", 6'h3F, doe);
    chk("irq masked", 1'b0, irq);
    apb(1'b0, SLDS_STATUS_OFS, 32'h0000003F);
    apb(1'b1, SLDS_MASK_OFS, SLDS_EVENT_BITS);
    repeat (3) @(posedge clk);
    chk("irq", 1'b1, irq);
    for (int r = 1; r >= 0; r--) begin
      @(posedge clk);
      rise <= r[0];
      repeat (100) @(posedge clk);
      #1;
      k = 0;
      j = 0;
      for (int i = 0; i < 96; i++) begin
        b = rclk[0];
        s = h1[0];
        @(posedge clk);
        #1;
        if (rclk[0] !== b) k++;
        if (rclk[0] !== b && rclk[0] === ~r[0] && h1[0] === 1'b1 && s === 1'b0) j++;
      end
      chk("rclk edges", 4, k);
      chk("rclk word edges", 2, j);
    end
    apb(1'b1, SLDS_STATUS_OFS, 32'h0000003F);
    repeat (3) @(posedge clk);
    chk("irq cleared", 1'b0, irq);
    en[5] <= 1'b0;
    repeat (200) @(posedge clk);
    chk("lock_n loss", 6'h20, lock_n);
    chk("data oe loss", 6'h1F, doe);
    chk("irq loss", 1'b1, irq);
    apb(1'b0, SLDS_STATUS_OFS, 32'h00002000);
    apb(1'b1, SLDS_STATUS_OFS, 32'h00002000);
    en[5] <= 1'b1;
    wait_lock();
    for (int c = 0; c < 8; c++) begin
      code <= c[2:0];
      repeat (5) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        @(posedge clk);
        #1;
        chk("monitor", (c == 7) ? h1[6] : (c < 6) ? h1[c] : 1'b0, mon);
        chk("monitor oe", c != 6, mon_oe);
      end
      @(posedge clk);
    end
    code <= 3'h2;
    wait_lock();
    #1;
    chk("spare data", exp_data(), data);
    @(posedge clk);
    oe <= 1'b0;
    repeat (5) @(posedge clk);
    chk("data oe off", 6'h00, doe);
    chk("lock kept", 6'h00, lock_n);
    oe <= 1'b1;
    pd_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk("lock pins off", 6'h00, lock_oe);
    pd_n <= 1'b1;
    wait_lock();
    results();
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule : slds_deser_tb
